// File: hw/add_call_exec_pkg.sv
package add_call_exec_pkg;

    // ************************************************************
    // Constants
    // ************************************************************
    localparam logic [7:0]  ESCAPE_BYTE      = 8'hA5;
    localparam logic [4:0]  CALL_OP_LOW      = 5'h11;
    localparam logic [3:0]  ADD_HI           = 4'h2;
    localparam logic [3:0]  SUM_WITH_CARRY_HI          = 4'h3;
    localparam logic [3:0]  LO_IMM           = 4'h4;
    localparam logic [3:0]  LO_DIR           = 4'h5;
    localparam logic [3:0]  LO_EXT_BYTE      = 4'hC;
    localparam logic [3:0]  LO_EXT_WORD      = 4'hD;
    localparam logic [3:0]  LO_EXT_IMM       = 4'hE;
    localparam logic [3:0]  LO_EXT_DWORD     = 4'hF;
    localparam logic [3:0]  EXT_IMM_SUB      = 4'h0;
    localparam logic [23:0] RETURN_STEP      = 24'h000002;
    localparam int          PAGE_LOW_BITS    = 11;
    localparam logic [15:0] STACK_RESET      = 16'h0007;
    localparam logic [3:0]  ACC_INDEX        = 4'hB;
    localparam logic [7:0]  PORT_ADDR0       = 8'h80;
    localparam logic [7:0]  PORT_ADDR1       = 8'h90;
    localparam logic [7:0]  PORT_ADDR2       = 8'hA0;
    localparam logic [7:0]  PORT_ADDR3       = 8'hB0;
    localparam logic [1:0]  PORT_EXTRA_ADD   = 2'h1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_DWORD} op_size_t;
    typedef enum logic [1:0] {SRC_REG, SRC_DIR, SRC_IND, SRC_IMM} src_form_t;
    typedef enum logic [2:0] {
        FX_KEEP, FX_UPDATE, FX_ONE, FX_ZERO, FX_UNDEF
    } flag_effect_t;

    typedef struct packed {
        logic       escape;
        logic [7:0] opcode;
        logic [7:0] byte1;
        logic [7:0] byte2;
    } instr_t;

    typedef struct packed {
        logic cy;
        logic ac;
        logic ov;
        logic n;
        logic z;
    } status_flags_t;

    typedef struct packed {
        flag_effect_t cy;
        flag_effect_t ac;
        flag_effect_t ov;
        flag_effect_t n;
        flag_effect_t z;
    } flag_effects_t;

endpackage

// File: hw/add_call_exec_unit.sv
`timescale 1ns/1ps
module add_call_exec_unit (
    input  wire logic                              i_clk_sys,
    input  wire logic                              i_arst_n,
    input  wire logic                              i_source_mode,
    input  wire logic                              i_instr_valid,
    input  wire add_call_exec_pkg::instr_t         i_instr,
    input  wire logic [23:0]                       i_fetch_pointer,
    output logic                                   o_instr_ready,
    output logic                                   o_done,
    output logic                                   o_illegal,
    output logic [3:0]                             o_rd_a_idx,
    output add_call_exec_pkg::op_size_t            o_rd_a_size,
    input  wire logic [31:0]                       i_rd_a_data,
    output logic [3:0]                             o_rd_b_idx,
    output add_call_exec_pkg::op_size_t            o_rd_b_size,
    input  wire logic [31:0]                       i_rd_b_data,
    output logic                                   o_reg_we,
    output logic [3:0]                             o_reg_widx,
    output add_call_exec_pkg::op_size_t            o_reg_wsize,
    output logic [31:0]                            o_reg_wdata,
    output logic                                   o_ram_rd,
    output logic                                   o_ram_we,
    output logic [15:0]                            o_ram_addr,
    output logic [7:0]                             o_ram_wdata,
    input  wire logic [7:0]                        i_ram_rdata,
    output logic                                   o_branch_valid,
    output logic [23:0]                            o_branch_target,
    output logic [15:0]                            o_stack_top_pointer,
    output add_call_exec_pkg::status_flags_t       o_program_status_word
);

    // ************************************************************
    // State and latched decode
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_RAM_RD, ST_RAM_WAIT, ST_PORT, ST_EXEC, ST_PUSH_LO, ST_PUSH_HI
    } exec_state_t;

    exec_state_t                     state;
    exec_state_t                     next_state;
    logic                            is_call;
    logic                            with_carry;
    add_call_exec_pkg::op_size_t     size;
    add_call_exec_pkg::src_form_t    src_form;
    logic [3:0]                      dst_idx;
    logic [3:0]                      src_idx;
    logic [7:0]                      dir_addr;
    logic [31:0]                     operand;
    logic [23:0]                     return_addr;
    logic [23:0]                     call_target;
    logic [1:0]                      extra_left;
    logic [15:0]                     stack_top;
    add_call_exec_pkg::status_flags_t flags;

    // Decode results, valid while idle
    logic                            dec_ok;
    logic                            dec_call;
    logic                            dec_carry;
    add_call_exec_pkg::op_size_t     dec_size;
    add_call_exec_pkg::src_form_t    dec_src;
    logic [3:0]                      dec_dst;
    logic [3:0]                      dec_sidx;
    logic [31:0]                     dec_imm;
    logic                            ext_page;
    logic                            accept;
    logic [23:0]                     next_fetch;

    assign o_instr_ready = (state == ST_IDLE);
    assign accept        = o_instr_ready && i_instr_valid;
    assign next_fetch    = i_fetch_pointer + add_call_exec_pkg::RETURN_STEP;

    // ************************************************************
    // Decoder
    // ************************************************************
    always_comb begin
        // Escape flips which page an opcode lands on, mode decides the sense
        ext_page  = i_instr.escape ^ i_source_mode;
        dec_ok    = 1'b0;
        dec_call  = 1'b0;
        dec_carry = (i_instr.opcode[7:4] == add_call_exec_pkg::SUM_WITH_CARRY_HI);
        dec_size  = add_call_exec_pkg::SZ_BYTE;
        dec_src   = add_call_exec_pkg::SRC_REG;
        dec_dst   = add_call_exec_pkg::ACC_INDEX;
        dec_sidx  = 4'h0;
        dec_imm   = {24'h000000, i_instr.byte1};
        if (i_instr.opcode[4:0] == add_call_exec_pkg::CALL_OP_LOW) begin
            dec_ok   = 1'b1;
            dec_call = 1'b1;
        end else if ((i_instr.opcode[7:4] == add_call_exec_pkg::ADD_HI) || dec_carry) begin
            if (i_instr.opcode[3:0] == add_call_exec_pkg::LO_IMM) begin
                dec_ok  = 1'b1;
                dec_src = add_call_exec_pkg::SRC_IMM;
            end else if (i_instr.opcode[3:0] == add_call_exec_pkg::LO_DIR) begin
                dec_ok  = 1'b1;
                dec_src = add_call_exec_pkg::SRC_DIR;
            end else if (!ext_page && (i_instr.opcode[3:1] == 3'h3)) begin
                dec_ok   = 1'b1;
                dec_src  = add_call_exec_pkg::SRC_IND;
                dec_sidx = {3'h0, i_instr.opcode[0]};
            end else if (!ext_page && i_instr.opcode[3]) begin
                dec_ok   = 1'b1;
                dec_sidx = {1'b0, i_instr.opcode[2:0]};
            end else if (ext_page && !dec_carry) begin
                dec_dst  = i_instr.byte1[7:4];
                dec_sidx = i_instr.byte1[3:0];
                unique case (i_instr.opcode[3:0])
                    add_call_exec_pkg::LO_EXT_BYTE: begin
                        dec_ok = 1'b1;
                    end
                    add_call_exec_pkg::LO_EXT_WORD: begin
                        dec_ok   = 1'b1;
                        dec_size = add_call_exec_pkg::SZ_WORD;
                    end
                    add_call_exec_pkg::LO_EXT_DWORD: begin
                        dec_ok   = 1'b1;
                        dec_size = add_call_exec_pkg::SZ_DWORD;
                    end
                    add_call_exec_pkg::LO_EXT_IMM: begin
                        dec_ok  = (i_instr.byte1[3:0] == add_call_exec_pkg::EXT_IMM_SUB);
                        dec_src = add_call_exec_pkg::SRC_IMM;
                        dec_imm = {24'h000000, i_instr.byte2};
                    end
                    default: begin
                        dec_ok = 1'b0;
                    end
                endcase
            end
        end
    end

    // ************************************************************
    // Arithmetic and flags
    // ************************************************************
    logic [31:0]   mask;
    logic [31:0]   add_a;
    logic [31:0]   add_b;
    logic [32:0]   sum;
    logic          carry_top;
    logic          carry_into_top;
    logic          msb_a;
    logic          msb_b;
    logic          msb_s;
    add_call_exec_pkg::status_flags_t result_flags;
    add_call_exec_pkg::status_flags_t next_flags;
    add_call_exec_pkg::flag_effects_t effects;

    function automatic logic apply_effect(add_call_exec_pkg::flag_effect_t fx,
                                          logic old_v, logic new_v);
        logic r;
        r = old_v;
        unique case (fx)
            add_call_exec_pkg::FX_KEEP:   r = old_v;
            add_call_exec_pkg::FX_UPDATE: r = new_v;
            add_call_exec_pkg::FX_ONE:    r = 1'b1;
            add_call_exec_pkg::FX_ZERO:   r = 1'b0;
            add_call_exec_pkg::FX_UNDEF:  r = old_v;
        endcase
        return r;
    endfunction

    always_comb begin
        unique case (size)
            add_call_exec_pkg::SZ_BYTE:  mask = 32'h000000FF;
            add_call_exec_pkg::SZ_WORD:  mask = 32'h0000FFFF;
            add_call_exec_pkg::SZ_DWORD: mask = 32'hFFFFFFFF;
            default:                     mask = 32'h000000FF;
        endcase
        add_a = i_rd_a_data & mask;
        add_b = ((src_form == add_call_exec_pkg::SRC_REG) ? i_rd_b_data : operand) & mask;
        // One adder for both forms; carry enters only for the carry form
        sum = {1'b0, add_a} + {1'b0, add_b} + {32'h00000000, with_carry & flags.cy};
        unique case (size)
            add_call_exec_pkg::SZ_BYTE: begin
                carry_top = sum[8];
                msb_a     = add_a[7];
                msb_b     = add_b[7];
                msb_s     = sum[7];
            end
            add_call_exec_pkg::SZ_WORD: begin
                carry_top = sum[16];
                msb_a     = add_a[15];
                msb_b     = add_b[15];
                msb_s     = sum[15];
            end
            default: begin
                carry_top = sum[32];
                msb_a     = add_a[31];
                msb_b     = add_b[31];
                msb_s     = sum[31];
            end
        endcase
        // Carry out of bit 6 of the top byte is the carry into its bit 7
        carry_into_top  = msb_s ^ msb_a ^ msb_b;
        result_flags.cy = carry_top;
        result_flags.ac = sum[4] ^ add_a[4] ^ add_b[4];
        result_flags.ov = carry_top ^ carry_into_top;
        result_flags.n  = msb_s;
        result_flags.z  = ((sum[31:0] & mask) == 32'h00000000);
        effects.cy = add_call_exec_pkg::FX_UPDATE;
        // Half carry means nothing above byte width, so it is kept there
        effects.ac = (size == add_call_exec_pkg::SZ_BYTE) ? add_call_exec_pkg::FX_UPDATE
                                                          : add_call_exec_pkg::FX_KEEP;
        effects.ov = add_call_exec_pkg::FX_UPDATE;
        effects.n  = add_call_exec_pkg::FX_UPDATE;
        effects.z  = add_call_exec_pkg::FX_UPDATE;
        next_flags.cy = apply_effect(effects.cy, flags.cy, result_flags.cy);
        next_flags.ac = apply_effect(effects.ac, flags.ac, result_flags.ac);
        next_flags.ov = apply_effect(effects.ov, flags.ov, result_flags.ov);
        next_flags.n  = apply_effect(effects.n, flags.n, result_flags.n);
        next_flags.z  = apply_effect(effects.z, flags.z, result_flags.z);
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    function automatic logic is_port(logic [7:0] a);
        return (a == add_call_exec_pkg::PORT_ADDR0) || (a == add_call_exec_pkg::PORT_ADDR1)
            || (a == add_call_exec_pkg::PORT_ADDR2) || (a == add_call_exec_pkg::PORT_ADDR3);
    endfunction

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (accept && dec_ok) begin
                    if (dec_call) begin
                        next_state = ST_PUSH_LO;
                    end else if ((dec_src == add_call_exec_pkg::SRC_DIR)
                              || (dec_src == add_call_exec_pkg::SRC_IND)) begin
                        next_state = ST_RAM_RD;
                    end else begin
                        next_state = ST_EXEC;
                    end
                end
            end
            ST_RAM_RD:   next_state = ST_RAM_WAIT;
            ST_RAM_WAIT: begin
                // Port reads are slower, so the add waits out one extra state
                next_state = ((src_form == add_call_exec_pkg::SRC_DIR) && is_port(dir_addr))
                             ? ST_PORT : ST_EXEC;
            end
            ST_PORT:     next_state = (extra_left == 2'h1) ? ST_EXEC : ST_PORT;
            ST_EXEC:     next_state = ST_IDLE;
            ST_PUSH_LO:  next_state = ST_PUSH_HI;
            ST_PUSH_HI:  next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            is_call     <= 1'b0;
            with_carry  <= 1'b0;
            size        <= add_call_exec_pkg::SZ_BYTE;
            src_form    <= add_call_exec_pkg::SRC_REG;
            dst_idx     <= 4'h0;
            src_idx     <= 4'h0;
            dir_addr    <= 8'h00;
            return_addr <= 24'h000000;
            call_target <= 24'h000000;
        end else if (accept) begin
            is_call     <= dec_call;
            with_carry  <= dec_carry;
            size        <= dec_size;
            src_form    <= dec_src;
            dst_idx     <= dec_dst;
            src_idx     <= dec_sidx;
            dir_addr    <= i_instr.byte1;
            return_addr <= next_fetch;
            // Only the low eleven bits change, so the page never moves
            call_target <= {next_fetch[23:add_call_exec_pkg::PAGE_LOW_BITS],
                            i_instr.opcode[7:5], i_instr.byte1};
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            operand    <= 32'h00000000;
            extra_left <= 2'h0;
        end else if (accept) begin
            operand    <= dec_imm;
            extra_left <= 2'h0;
        end else if (state == ST_RAM_WAIT) begin
            operand    <= {24'h000000, i_ram_rdata};
            extra_left <= ((src_form == add_call_exec_pkg::SRC_DIR) && is_port(dir_addr))
                          ? add_call_exec_pkg::PORT_EXTRA_ADD : 2'h0;
        end else if ((state == ST_PORT) && (extra_left != 2'h0)) begin
            extra_left <= extra_left - 2'h1;
        end
    end

    // ************************************************************
    // Register file, memory and stack ports
    // ************************************************************
    assign o_rd_a_idx  = dst_idx;
    assign o_rd_a_size = size;
    assign o_rd_b_idx  = src_idx;
    assign o_rd_b_size = (src_form == add_call_exec_pkg::SRC_IND) ? add_call_exec_pkg::SZ_BYTE
                                                                  : size;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_we    <= 1'b0;
            o_reg_widx  <= 4'h0;
            o_reg_wsize <= add_call_exec_pkg::SZ_BYTE;
            o_reg_wdata <= 32'h00000000;
        end else begin
            o_reg_we <= (state == ST_EXEC);
            if (state == ST_EXEC) begin
                o_reg_widx  <= dst_idx;
                o_reg_wsize <= size;
                o_reg_wdata <= sum[31:0] & mask;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_ram_rd    <= 1'b0;
            o_ram_we    <= 1'b0;
            o_ram_addr  <= 16'h0000;
            o_ram_wdata <= 8'h00;
            stack_top   <= add_call_exec_pkg::STACK_RESET;
        end else begin
            o_ram_rd <= (state == ST_RAM_RD);
            o_ram_we <= (state == ST_PUSH_LO) || (state == ST_PUSH_HI);
            if (state == ST_RAM_RD) begin
                o_ram_addr <= (src_form == add_call_exec_pkg::SRC_IND)
                              ? {8'h00, i_rd_b_data[7:0]} : {8'h00, dir_addr};
            end else if ((state == ST_PUSH_LO) || (state == ST_PUSH_HI)) begin
                // Increment first, then write: the pointer always names the top byte
                o_ram_addr  <= stack_top + 16'h0001;
                o_ram_wdata <= (state == ST_PUSH_LO) ? return_addr[7:0] : return_addr[15:8];
                stack_top   <= stack_top + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_branch_valid  <= 1'b0;
            o_branch_target <= 24'h000000;
        end else begin
            o_branch_valid <= (state == ST_PUSH_HI);
            if (state == ST_PUSH_HI) begin
                o_branch_target <= call_target;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_done    <= 1'b0;
            o_illegal <= 1'b0;
        end else begin
            o_done    <= (state == ST_EXEC) || (state == ST_PUSH_HI);
            o_illegal <= accept && !dec_ok;
        end
    end

    // ************************************************************
    // Status flags
    // ************************************************************
    // Call never reaches the exec state, so its flags stay as they were
    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flags <= '0;
        end else if ((state == ST_EXEC) && !is_call) begin
            flags <= next_flags;
        end
    end

    // Pre-execution flags stay visible for jump decisions through the exec state, one cycle before write-back lands
    assign o_program_status_word = flags;
    assign o_stack_top_pointer   = stack_top;

endmodule // add_call_exec_unit

// File: tb/add_call_exec_chk.sv
`timescale 1ns/1ps
module add_call_exec_chk (
    input wire logic                            i_clk_sys,
    input wire logic                            i_arst_n,
    input wire logic                            i_source_mode,
    input wire logic                            i_instr_valid,
    input wire add_call_exec_pkg::instr_t       i_instr,
    input wire logic                            o_instr_ready,
    input wire logic                            o_done,
    input wire logic                            o_ram_we,
    input wire logic [15:0]                     o_ram_addr,
    input wire logic [7:0]                      o_ram_wdata,
    input wire logic                            o_branch_valid,
    input wire logic [23:0]                     o_branch_target,
    input wire logic [15:0]                     o_stack_top_pointer,
    input wire add_call_exec_pkg::status_flags_t o_program_status_word
);
    logic take;
    logic port;
    // Normal page only: escape cancels the decode mode
    assign take = i_instr_valid && o_instr_ready && i_instr.escape == i_source_mode;
    assign port = i_instr.byte1 inside {8'h80, 8'h90, 8'hA0, 8'hB0};
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    AST_DONE_PULSE: assert property (o_done |=> !o_done)
        else $error("done held over two cycles");
    AST_PUSH_PAIR: assert property (o_branch_valid |-> o_ram_we && $past(o_ram_we)
        && o_ram_addr == $past(o_ram_addr) + 16'h0001) else $error("push pair wrong");
    AST_CALL_PAGE: assert property (o_branch_valid
        |-> o_branch_target[15:11] == o_ram_wdata[7:3]) else $error("target page wrong");
    AST_CALL_SP: assert property (o_branch_valid
        |=> o_stack_top_pointer == $past(o_ram_addr)) else $error("stack top wrong");
    AST_CALL_FLAGS: assert property (o_branch_valid
        |-> o_program_status_word == $past(o_program_status_word, 3)) else $error("call flags");
    AST_IMM_LAT: assert property (take && i_instr.opcode == 8'h24
        |=> !o_done ##1 o_done) else $error("immediate add latency");
    AST_DIR_LAT: assert property (take && i_instr.opcode == 8'h25 && !port
        |=> !o_done [*3] ##1 o_done) else $error("direct add latency");
    AST_PORT_LAT: assert property (take && i_instr.opcode == 8'h25 && port
        |=> !o_done [*4] ##1 o_done) else $error("port add latency");
endmodule // add_call_exec_chk
bind add_call_exec_unit add_call_exec_chk u_chk (.*);

// File: tb/add_call_exec_mem.sv
`timescale 1ns/1ps
module add_call_exec_mem (
    input  logic        i_clk_sys,
    input  logic [3:0]  i_a_idx,
    input  logic [3:0]  i_b_idx,
    input  logic        i_we,
    input  logic [3:0]  i_widx,
    input  logic [31:0] i_wdata,
    input  logic        i_rd,
    input  logic        i_ram_we,
    input  logic [15:0] i_addr,
    input  logic [7:0]  i_ram_wdata,
    output logic [31:0] o_a_data,
    output logic [31:0] o_b_data,
    output logic [7:0]  o_ram_rdata
);
    logic [31:0] regs [16];
    logic [7:0]  ram [256];
    initial foreach (ram[k]) ram[k] = 8'h00;
    assign o_a_data = regs[i_a_idx];
    assign o_b_data = regs[i_b_idx];
    // Idle read bus shows inverse so stale data never passes
    assign o_ram_rdata = i_rd ? ram[i_addr[7:0]] : ~ram[i_addr[7:0]];
    always @(posedge i_clk_sys) begin
        if (i_we) regs[i_widx] <= i_wdata;
        if (i_ram_we) ram[i_addr[7:0]] <= i_ram_wdata;
    end
endmodule // add_call_exec_mem

// File: tb/add_call_exec_unit_tb_top.sv
`timescale 1ns/1ps
module add_call_exec_unit_tb_top;
    logic i_clk_sys, i_arst_n, i_source_mode, i_instr_valid, o_instr_ready, o_done, o_illegal;
    logic o_reg_we, o_ram_rd, o_ram_we, o_branch_valid;
    logic [3:0] o_rd_a_idx, o_rd_b_idx, o_reg_widx;
    add_call_exec_pkg::op_size_t o_rd_a_size, o_rd_b_size, o_reg_wsize;
    add_call_exec_pkg::instr_t i_instr;
    add_call_exec_pkg::status_flags_t o_program_status_word;
    logic [23:0] i_fetch_pointer, o_branch_target;
    logic [31:0] i_rd_a_data, i_rd_b_data, o_reg_wdata;
    logic [15:0] o_ram_addr, o_stack_top_pointer;
    logic [7:0] o_ram_wdata, i_ram_rdata;
    int failures, samples_checked;
    add_call_exec_unit uut (.*);
    add_call_exec_mem u_mem (.i_clk_sys(i_clk_sys), .i_a_idx(o_rd_a_idx), .i_b_idx(o_rd_b_idx),
        .i_we(o_reg_we), .i_widx(o_reg_widx), .i_wdata(o_reg_wdata), .i_rd(o_ram_rd),
        .i_ram_we(o_ram_we), .i_addr(o_ram_addr), .i_ram_wdata(o_ram_wdata),
        .o_a_data(i_rd_a_data), .o_b_data(i_rd_b_data), .o_ram_rdata(i_ram_rdata));
    initial begin
        i_clk_sys = 0;
        forever #25 i_clk_sys = ~i_clk_sys;
    end
    task test_done;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (e !== g) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask
    // Offer one instruction, count cycles to done, let write-back land
    task run(input logic m, input logic e, input logic [7:0] op, input logic [7:0] b1,
             input int n);
        int k;
        @(posedge i_clk_sys); #1;
        i_source_mode = m;
        i_instr = '{e, op, b1, 8'h00};
        i_instr_valid = 1;
        @(posedge i_clk_sys); #1;
        i_instr_valid = 0;
        k = 1;
        while (o_done !== 1'b1 && k < 20) begin
            @(posedge i_clk_sys); #1;
            k++;
        end
        chk("cycles", n, k);
        @(posedge i_clk_sys); #1;
    endtask
    task t_imm;
        u_mem.regs[11] = 32'h0000_00C3;
        run(0, 0, 8'h24, 8'hAA, 2);
        chk("acc", 32'h6D, u_mem.regs[11]);
        chk("flags", 5'h14, o_program_status_word);
        run(0, 0, 8'h34, 8'h0F, 2);
        chk("acc", 32'h7D, u_mem.regs[11]);
        chk("flags", 5'h08, o_program_status_word);
    endtask
    task t_mem;
        u_mem.ram[8'h30] = 8'h83;
        u_mem.ram[8'h40] = 8'h80;
        u_mem.regs[0] = 32'h0000_0040;
        run(0, 0, 8'h25, 8'h30, 4);
        chk("flags", 5'h19, o_program_status_word);
        run(0, 0, 8'h25, 8'h90, 5);
        chk("flags", 5'h01, o_program_status_word);
        run(1, 1, 8'h26, 8'h00, 4);
        chk("acc", 32'h80, u_mem.regs[11]);
        chk("flags", 5'h02, o_program_status_word);
    endtask
    task t_wide;
        u_mem.regs[2] = 32'h0000_7FFF;
        u_mem.regs[4] = 32'h0000_0001;
        run(1, 0, 8'h2D, 8'h24, 2);
        chk("word", 32'h8000, u_mem.regs[2]);
        chk("flags", 5'h06, o_program_status_word);
        run(0, 1, 8'h2D, 8'h22, 2);
        chk("word", 32'h0000, u_mem.regs[2]);
        chk("flags", 5'h15, o_program_status_word);
        // Carry form has no extended page, so it must be refused
        @(posedge i_clk_sys); #1;
        i_instr = '{1'b1, 8'h3D, 8'h22, 8'h00};
        i_instr_valid = 1;
        @(posedge i_clk_sys); #1;
        i_instr_valid = 0;
        chk("illegal", 1, o_illegal);
        chk("ready", 1, o_instr_ready);
        chk("word kept", 32'h0000, u_mem.regs[2]);
    endtask
    task t_call;
        run(0, 0, 8'hB1, 8'h45, 3);
        chk("target", 24'h000D45, o_branch_target);
        chk("ret lo", 8'h00, u_mem.ram[8]);
        chk("ret hi", 8'h08, u_mem.ram[9]);
        chk("stack", 16'h0009, o_stack_top_pointer);
        chk("flags", 5'h15, o_program_status_word);
    endtask
    initial begin
        repeat (500) @(posedge i_clk_sys);
        failures++;
        test_done;
    end
    initial begin
        i_arst_n = 0;
        i_source_mode = 0;
        i_instr_valid = 0;
        i_instr = '0;
        i_fetch_pointer = 24'h0007FE;
        repeat (3) @(posedge i_clk_sys);
        #1 i_arst_n = 1;
        t_imm;
        t_mem;
        t_wide;
        t_call;
        test_done;
    end
endmodule // add_call_exec_unit_tb_top
